// ---- hw/ivp_pkg.sv ----
// Constants, types and register map of the vectored interrupt priority block.
// Assumes one system clock and an Avalon-MM slave with a 32-bit byte address.
// Functional notes
// RULE_01: Mask bits 25..0 per source, bit 26 global; 1 blocks; all reset to 1.
// RULE_02: Software masks a source only while that source is certainly not requesting.
// RULE_03: Priority logic is one master unit plus four slave units of six sources.
// RULE_04: Each slave ranks four programmable sources and holds two fixed sources.
// RULE_05: Fixed sources of a slave always lose to its four programmable sources.
// RULE_06: Master ranks four slave winners by master ranking, then takes two direct sources after them.
// RULE_07: Clock tick and converter direct sources are lowest of all 26.
// RULE_08: With several requests, in-service shows only the highest-priority one.
// RULE_09: In-service register is read-only, one-hot or zero, resets to zero.
// RULE_10: Service clear is write-only; a write clears pending bits and in-service.
// RULE_11: Fast-routed sources get no in-service bit; software reads pending instead.
// RULE_12: Slave ranking is four 8-bit group fields, group A on top, each 0x1B.
// RULE_13: Each field holds four 2-bit rank codes, source A first; 00 ranks highest.
// RULE_14: Groups hold external 0-3, transfer, timer 0-3 and serial/two-wire sources.
// RULE_15: Software gives the four sources of each group distinct rank codes.
// RULE_16: A pending bit sets on request even while its source is masked.
// RULE_17: Master ranking bit 12 master mode, bits 11..8 slave modes; 0 round robin.
// RULE_18: Current slave ranking reports the ranking in use, rotated under round robin.
// RULE_19: Normal request is high while global mask clear and an unmasked normal source pends.

package ivp_pkg;

  localparam int NUM_SRC  = 26;
  localparam int NUM_GRP  = 4;

  // Register byte addresses
  localparam logic [31:0] ADDR_PENDING     = 32'h01E00004;
  localparam logic [31:0] ADDR_ROUTE       = 32'h01E00008;
  localparam logic [31:0] ADDR_BLOCK       = 32'h01E0000C;
  localparam logic [31:0] ADDR_SLV_CFG     = 32'h01E00010;
  localparam logic [31:0] ADDR_MST_CFG     = 32'h01E00014;
  localparam logic [31:0] ADDR_SLV_CUR     = 32'h01E00018;
  localparam logic [31:0] ADDR_MST_CUR     = 32'h01E0001C;
  localparam logic [31:0] ADDR_IN_SERVICE  = 32'h01E00020;
  localparam logic [31:0] ADDR_SVC_CLEAR   = 32'h01E00024;
  localparam logic [31:0] ADDR_EVT_STATUS  = 32'h01E00028;
  localparam logic [31:0] ADDR_EVT_CLEAR   = 32'h01E0002C;
  localparam logic [31:0] ADDR_EVT_ENABLE  = 32'h01E00030;

  // Field positions
  localparam int BIT_GLOBAL      = 26;
  localparam int BIT_MST_MODE    = 12;
  localparam int BIT_SLV_MODE_A  = 11;
  localparam int SRC_CLOCK_TICK  = 1;
  localparam int SRC_CONVERTER   = 0;
  localparam int EVT_GRANT       = 0;
  localparam int EVT_MASKED_REQ  = 1;

  // Top bit of each group: sources base..base-3 programmable, base-4, base-5 fixed
  localparam logic [4:0] GRP_BASE [NUM_GRP] = '{5'h19, 5'h13, 5'h0D, 5'h07};

  // Reset values
  localparam logic [27:0] RST_BLOCK    = 28'h7FFFFFF;
  localparam logic [31:0] RST_SLV_RANK = 32'h1B1B1B1B;
  localparam logic [12:0] RST_MST_CFG  = 13'h1F1B;
  localparam logic [7:0]  RST_MST_RANK = 8'h1B;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ivp_av_req_type;

  typedef enum logic {
    IVP_IDLE,
    IVP_ANSWER
  } ivp_bus_state_type;

endpackage

// ---- hw/ivp_irq_ctrl.sv ----
// Interrupt mask, pending flags and vectored two-level priority arbitration.
// Assumes source requests are levels from logic on core_clk.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps

module ivp_irq_ctrl (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Avalon-MM slave
  input  wire ivp_pkg::ivp_av_req_type av_req,
  output logic                        av_waitrequest,
  output logic [31:0]                 av_readdata,
  // Sources and core requests
  input  wire logic [25:0]            source_req,
  output logic                        normal_irq,
  output logic                        fast_irq,
  output logic                        event_irq
);
  import ivp_pkg::*;

  ivp_bus_state_type bus_state;
  logic [25:0]       request_flags;
  logic [25:0]       fast_route;
  logic [27:0]       source_block_bits;
  logic [31:0]       slave_rank_config;
  logic [12:0]       master_rank_config;
  logic [31:0]       slave_rank_current;
  logic [7:0]        master_rank_current;
  logic [25:0]       in_service_flags;
  logic [1:0]        evt_status;
  logic [1:0]        evt_enable;

  logic              wr_take;
  logic              rd_take;
  logic [31:0]       wr_mask;
  logic [31:0]       wr_val;
  logic [25:0]       candidates;
  logic [NUM_GRP-1:0] slv_hit;
  logic [1:0]        slv_k [NUM_GRP];
  logic [4:0]        slv_src [NUM_GRP];
  logic              win_any;
  logic [4:0]        win_src;
  logic              win_is_grp;
  logic [1:0]        win_grp;
  logic              grant;
  logic              svc_wr;
  logic [1:0]        evt_new;
  logic [31:0]       next_slave_rank_config;
  logic [12:0]       next_master_rank_config;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, read data registered before waitrequest drops

  assign av_waitrequest = (av_req.read | av_req.write) & (bus_state == IVP_IDLE);
  assign wr_take = av_req.write & (bus_state == IVP_ANSWER);
  assign rd_take = av_req.read & (bus_state == IVP_IDLE);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{av_req.byteenable[b]}};
    end
    wr_val = av_req.writedata & wr_mask;
  end

  // Values a config write leaves behind, so a reload never picks up the old word
  assign next_slave_rank_config  = (slave_rank_config & ~wr_mask) | wr_val;
  assign next_master_rank_config = (master_rank_config & ~wr_mask[12:0]) | wr_val[12:0];
  assign svc_wr                  = wr_take && (av_req.address == ADDR_SVC_CLEAR);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_state <= IVP_IDLE;
    end else if (bus_state == IVP_ANSWER) begin
      bus_state <= IVP_IDLE;
    end else if (av_req.read | av_req.write) begin
      bus_state <= IVP_ANSWER;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      av_readdata <= 32'h00000000;
    end else if (rd_take) begin
      unique case (av_req.address)
        ADDR_PENDING:    av_readdata <= {6'h00, request_flags};
        ADDR_ROUTE:      av_readdata <= {6'h00, fast_route};
        ADDR_BLOCK:      av_readdata <= {4'h0, source_block_bits};
        ADDR_SLV_CFG:    av_readdata <= slave_rank_config;
        ADDR_MST_CFG:    av_readdata <= {19'h00000, master_rank_config};
        ADDR_SLV_CUR:    av_readdata <= slave_rank_current;
        ADDR_MST_CUR:    av_readdata <= {24'h000000, master_rank_current};
        ADDR_IN_SERVICE: av_readdata <= {6'h00, in_service_flags}; // [RULE_09]
        ADDR_EVT_STATUS: av_readdata <= {30'h00000000, evt_status};
        ADDR_EVT_ENABLE: av_readdata <= {30'h00000000, evt_enable};
        // Write-only and unmapped words read as zero
        default:         av_readdata <= 32'h00000000;               // [RULE_10]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      source_block_bits <= RST_BLOCK;                               // [RULE_01]
    end else if (wr_take && av_req.address == ADDR_BLOCK) begin
      // Bit 27 is reserved and stays zero
      source_block_bits <= (source_block_bits & ~wr_mask[27:0])
                         | {1'b0, wr_val[26:0]};                    // [RULE_01]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fast_route <= 26'h0000000;
    end else if (wr_take && av_req.address == ADDR_ROUTE) begin
      fast_route <= (fast_route & ~wr_mask[25:0]) | wr_val[25:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slave_rank_config <= RST_SLV_RANK;                            // [RULE_12]
    end else if (wr_take && av_req.address == ADDR_SLV_CFG) begin
      slave_rank_config <= (slave_rank_config & ~wr_mask) | wr_val;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      master_rank_config <= RST_MST_CFG;                            // [RULE_17]
    end else if (wr_take && av_req.address == ADDR_MST_CFG) begin
      master_rank_config <= (master_rank_config & ~wr_mask[12:0]) | wr_val[12:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags: a new request beats a clear in the same cycle

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      request_flags <= 26'h0000000;
    end else if (wr_take && av_req.address == ADDR_SVC_CLEAR) begin
      request_flags <= (request_flags & ~wr_val[25:0]) | source_req; // [RULE_10] [RULE_16]
    end else begin
      request_flags <= request_flags | source_req;                  // [RULE_16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Fast-routed sources never enter the tree
  assign candidates = request_flags & ~source_block_bits[25:0] & ~fast_route
                    & {26{~source_block_bits[BIT_GLOBAL]}};          // [RULE_11]

  // Moves the granted code to last place, closing the gap behind it
  function automatic logic [7:0] rotate_ranks(input logic [7:0] f, input logic [1:0] k);
    logic [1:0] rk;
    logic [1:0] rj;
    rotate_ranks = f;
    rk = f[7-2*k -: 2];
    for (int j = 0; j < 4; j++) begin
      rj = f[7-2*j -: 2];
      if (j == int'(k)) begin
        rotate_ranks[7-2*j -: 2] = 2'h3;
      end else if (rj > rk) begin
        rotate_ranks[7-2*j -: 2] = rj - 2'h1;
      end
    end
  endfunction

  generate
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_slave                // [RULE_03]
      always_comb begin
        logic [7:0] f;
        logic [4:0] base;
        f = slave_rank_current[31-8*g -: 8];
        base = GRP_BASE[g];
        slv_hit[g] = 1'b0;
        slv_k[g] = 2'h0;
        slv_src[g] = 5'h00;
        // Lowest code wins; clashing codes fall back to source order
        for (int r = 0; r < 4; r++) begin
          for (int k = 0; k < 4; k++) begin
            if (!slv_hit[g] && candidates[base - 5'(k)] && f[7-2*k -: 2] == 2'(r)) begin
              slv_hit[g] = 1'b1;                                     // [RULE_04] [RULE_13]
              slv_k[g] = 2'(k);
              slv_src[g] = base - 5'(k);
            end
          end
        end
        // Fixed pair is only reached when no programmable source is among the candidates
        if (!slv_hit[g] && candidates[base - 5'h04]) begin
          slv_hit[g] = 1'b1;                                         // [RULE_05]
          slv_k[g] = 2'h0;
          slv_src[g] = base - 5'h04;
        end else if (!slv_hit[g] && candidates[base - 5'h05]) begin
          slv_hit[g] = 1'b1;                                         // [RULE_05] [RULE_14]
          slv_k[g] = 2'h0;
          slv_src[g] = base - 5'h05;
        end
      end
    end
  endgenerate

  always_comb begin
    win_any = 1'b0;
    win_src = 5'h00;
    win_is_grp = 1'b0;
    win_grp = 2'h0;
    for (int r = 0; r < 4; r++) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        if (!win_any && slv_hit[g] && master_rank_current[7-2*g -: 2] == 2'(r)) begin
          win_any = 1'b1;                                            // [RULE_06]
          win_src = slv_src[g];
          win_is_grp = 1'b1;
          win_grp = 2'(g);
        end
      end
    end
    if (!win_any && candidates[SRC_CLOCK_TICK]) begin
      win_any = 1'b1;                                                // [RULE_07]
      win_src = 5'(SRC_CLOCK_TICK);
    end else if (!win_any && candidates[SRC_CONVERTER]) begin
      win_any = 1'b1;                                                // [RULE_07]
      win_src = 5'(SRC_CONVERTER);
    end
  end

  // A new source is granted only while nothing is in service; a clear in
  // the same cycle defers it, so no ranking rotates without a service
  assign grant = win_any && (in_service_flags == 26'h0000000) && !svc_wr;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_service_flags <= 26'h0000000;                               // [RULE_09]
    end else if (wr_take && av_req.address == ADDR_SVC_CLEAR) begin
      // Any write ends service, whatever the data
      in_service_flags <= 26'h0000000;                               // [RULE_10]
    end else if (grant) begin
      in_service_flags <= 26'h0000001 << win_src;                    // [RULE_08] [RULE_09]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current rankings: track the program in fixed mode, rotate per grant otherwise

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slave_rank_current <= RST_SLV_RANK;                            // [RULE_18]
    end else begin
      for (int g = 0; g < NUM_GRP; g++) begin
        if (wr_take && av_req.address == ADDR_SLV_CFG) begin
          slave_rank_current[31-8*g -: 8] <= next_slave_rank_config[31-8*g -: 8];
        end else if (master_rank_config[BIT_SLV_MODE_A - g]) begin
          slave_rank_current[31-8*g -: 8] <= slave_rank_config[31-8*g -: 8];
        end else if (grant && win_is_grp && win_grp == 2'(g)
                     && win_src > GRP_BASE[g] - 5'h04) begin
          slave_rank_current[31-8*g -: 8] <=
            rotate_ranks(slave_rank_current[31-8*g -: 8], slv_k[g]); // [RULE_17] [RULE_18]
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      master_rank_current <= RST_MST_RANK;
    end else if (wr_take && av_req.address == ADDR_MST_CFG) begin
      master_rank_current <= next_master_rank_config[7:0];
    end else if (master_rank_config[BIT_MST_MODE]) begin
      master_rank_current <= master_rank_config[7:0];
    end else if (grant && win_is_grp) begin
      master_rank_current <= rotate_ranks(master_rank_current, win_grp); // [RULE_17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core requests and block events

  assign normal_irq = !source_block_bits[BIT_GLOBAL]
                    && |(request_flags & ~source_block_bits[25:0] & ~fast_route); // [RULE_19]
  assign fast_irq   = !source_block_bits[BIT_GLOBAL]
                    && |(request_flags & ~source_block_bits[25:0] & fast_route);  // [RULE_11]

  // Sticky events; a new event wins over a clear in the same cycle
  assign evt_new = {|(source_req & ~request_flags & source_block_bits[25:0]), grant};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_status <= 2'h0;
    end else if (wr_take && av_req.address == ADDR_EVT_CLEAR) begin
      evt_status <= (evt_status & ~wr_val[1:0]) | evt_new;
    end else begin
      evt_status <= evt_status | evt_new;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_enable <= 2'h0;
    end else if (wr_take && av_req.address == ADDR_EVT_ENABLE) begin
      evt_enable <= (evt_enable & ~wr_mask[1:0]) | wr_val[1:0];
    end
  end

  assign event_irq = |(evt_status & evt_enable);

endmodule

// ---- sim/ivp_core_model.sv ----
// Core-side model: takes a request once it has stood a set number of cycles.
// Assumes request levels come from logic on the same clock.
`timescale 1ns/1ps
module ivp_core_model #(
  parameter int LATENCY = 1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Request lines
  input  wire logic normal_irq,
  input  wire logic fast_irq,
  output logic      irq_taken
);
  int held;
  // Slow core: a short glitch is never taken
  always_ff @(posedge core_clk) begin
    if (!rst_n || !(normal_irq || fast_irq))
      held <= 0;
    else if (held < LATENCY)
      held <= held + 1;
  end
  assign irq_taken = (held == LATENCY);
endmodule

// ---- sim/ivp_checker.sv ----
// Checker of bus timing, read-back fields and request outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module ivp_checker (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  // Register bus
  input wire ivp_pkg::ivp_av_req_type av_req,
  input wire logic                    av_waitrequest,
  input wire logic [31:0]             av_readdata,
  // Sources and requests
  input wire logic [25:0]             source_req,
  input wire logic                    normal_irq,
  input wire logic                    fast_irq,
  input wire logic                    event_irq
);
  import ivp_pkg::*;
  logic req;
  logic rd_ok;
  assign req   = av_req.read | av_req.write;
  assign rd_ok = av_req.read & ~av_waitrequest;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  wait_first_a: assert property (req && !$past(req) |-> av_waitrequest)
    else $error("no wait in first bus cycle");
  wait_second_a: assert property (req && !$past(req) |=> !av_waitrequest)
    else $error("bus answer not in second cycle");
  svc_onehot_a: assert property (rd_ok && av_req.address == ADDR_IN_SERVICE |->
    $onehot0(av_readdata) && av_readdata[31:26] == 6'h00) else $error("in-service not one-hot");
  clear_read_a: assert property (rd_ok && av_req.address == ADDR_SVC_CLEAR |->
    av_readdata == 32'h00000000) else $error("service clear reads nonzero");
  block_top_a: assert property (rd_ok && av_req.address == ADDR_BLOCK |->
    av_readdata[31:27] == 5'h00) else $error("mask reserved bits set");
  mode_top_a: assert property (rd_ok && av_req.address == ADDR_MST_CFG |->
    av_readdata[31:13] == 19'h00000) else $error("master ranking upper bits set");
  irq_cause_a: assert property ($rose(normal_irq) || $rose(fast_irq) |->
    $past(|source_req) || $past(av_req.write)) else $error("request rose without cause");
  event_cause_a: assert property ($rose(event_irq) |->
    $past(av_req.write || normal_irq || |source_req)) else $error("event rose without cause");
  cover property ($rose(normal_irq));
  cover property ($rose(fast_irq));
  cover property (rd_ok && av_req.address == ADDR_IN_SERVICE && av_readdata != 32'h0);
endmodule

// ---- sim/ivp_irq_ctrl_bench.sv ----
// Bench of the vectored interrupt priority block, one task per scenario.
// Assumes the core model and checker are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %0t: %h not %h", $time, (g), (e)); end end
module ivp_irq_ctrl_bench;
  import ivp_pkg::*;
  logic           core_clk = 1'b0;
  logic           rst_n = 1'b0;
  ivp_av_req_type av_req = '0;
  logic [25:0]    source_req = '0;
  logic           av_waitrequest;
  logic           normal_irq;
  logic           fast_irq;
  logic           event_irq;
  logic           irq_taken;
  logic [31:0]    av_readdata;
  logic [31:0]    d;
  int             errors = 0;
  int             comparisons = 0;
  always #20 core_clk = ~core_clk;
  ivp_irq_ctrl u_ivp_irq_ctrl (.core_clk(core_clk), .rst_n(rst_n), .av_req(av_req),
    .av_waitrequest(av_waitrequest), .av_readdata(av_readdata), .source_req(source_req),
    .normal_irq(normal_irq), .fast_irq(fast_irq), .event_irq(event_irq));
  ivp_core_model #(.LATENCY(3)) u_ivp_core_model (.core_clk(core_clk), .rst_n(rst_n),
    .normal_irq(normal_irq), .fast_irq(fast_irq), .irq_taken(irq_taken));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [31:0] a, w);
    int n;
    n = 0;
    @(posedge core_clk);
    av_req <= '{rd, ~rd, a, 4'hF, w};
    // Waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge core_clk);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 20);
    d = av_readdata;
    av_req <= '0;
    if (av_waitrequest !== 1'b0) begin
      errors++;
      results();
    end
  endtask
  task automatic wr(input logic [31:0] a, w);
    bus(1'b0, a, w);
  endtask
  task automatic rc(input logic [31:0] a, e);
    bus(1'b1, a, 32'h0);
    `CHK(d, e)
  endtask
  task automatic pulse(input logic [25:0] m);
    @(posedge core_clk);
    source_req <= m;
    @(posedge core_clk);
    source_req <= '0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc(ADDR_BLOCK, 32'h07FFFFFF);
    rc(ADDR_SLV_CFG, 32'h1B1B1B1B);
    rc(ADDR_MST_CFG, 32'h00001F1B);
    rc(ADDR_SLV_CUR, 32'h1B1B1B1B);
    rc(ADDR_MST_CUR, 32'h0000001B);
    rc(ADDR_SVC_CLEAR, 32'h00000000);
    wr(ADDR_IN_SERVICE, 32'h00000001);
    rc(ADDR_IN_SERVICE, 32'h00000000);
    rc(32'h01E00040, 32'h00000000);
  endtask
  task automatic t_masked;
    pulse(26'h2000000);
    `CHK(normal_irq, 1'b0)
    rc(ADDR_PENDING, 32'h02000000);
    wr(ADDR_SVC_CLEAR, 32'h02000000);
    rc(ADDR_PENDING, 32'h00000000);
  endtask
  task automatic t_order;
    int exp [5] = '{22, 21, 14, 1, 0};
    int n;
    wr(ADDR_BLOCK, 32'h00000000);
    pulse(26'h0604003);
    for (n = 0; n < 20 && irq_taken !== 1'b1; n++)
      @(negedge core_clk);
    `CHK(irq_taken, 1'b1)
    if (irq_taken !== 1'b1) begin
      results();
    end
    foreach (exp[i]) begin
      rc(ADDR_IN_SERVICE, 32'h1 << exp[i]);
      wr(ADDR_SVC_CLEAR, 32'h1 << exp[i]);
    end
    @(negedge core_clk);
    `CHK(normal_irq, 1'b0)
  endtask
  task automatic t_rank;
    wr(ADDR_SLV_CFG, 32'hE41B1B1B);
    rc(ADDR_SLV_CUR, 32'hE41B1B1B);
    pulse(26'h3000000);
    rc(ADDR_IN_SERVICE, 32'h01000000);
    wr(ADDR_SVC_CLEAR, 32'h01000000);
    rc(ADDR_IN_SERVICE, 32'h02000000);
    wr(ADDR_SVC_CLEAR, 32'h02000000);
    wr(ADDR_SLV_CFG, 32'h1B1B1B1B);
  endtask
  task automatic t_robin;
    wr(ADDR_MST_CFG, 32'h0000071B);
    pulse(26'h2000000);
    rc(ADDR_IN_SERVICE, 32'h02000000);
    rc(ADDR_SLV_CUR, 32'hC61B1B1B);
    rc(ADDR_MST_CUR, 32'h000000C6);
    wr(ADDR_SVC_CLEAR, 32'h02000000);
    wr(ADDR_MST_CFG, 32'h00001F1B);
  endtask
  task automatic t_global;
    wr(ADDR_BLOCK, 32'h04000000);
    pulse(26'h1000000);
    `CHK(normal_irq, 1'b0)
    rc(ADDR_IN_SERVICE, 32'h00000000);
    wr(ADDR_ROUTE, 32'h01000000);
    wr(ADDR_BLOCK, 32'h00000000);
    @(negedge core_clk);
    `CHK(fast_irq, 1'b1)
    `CHK(normal_irq, 1'b0)
    rc(ADDR_IN_SERVICE, 32'h00000000);
    rc(ADDR_PENDING, 32'h01000000);
    wr(ADDR_SVC_CLEAR, 32'h01000000);
    wr(ADDR_ROUTE, 32'h00000000);
  endtask
  // Grant event from source 3, arrival event from masked source 2
  task automatic t_event;
    wr(ADDR_EVT_CLEAR, 32'h00000003);
    wr(ADDR_BLOCK, 32'h00000004);
    pulse(26'h000000C);
    `CHK(event_irq, 1'b0)
    rc(ADDR_EVT_STATUS, 32'h00000003);
    wr(ADDR_EVT_ENABLE, 32'h00000003);
    @(negedge core_clk);
    `CHK(event_irq, 1'b1)
    wr(ADDR_EVT_CLEAR, 32'h00000003);
    @(negedge core_clk);
    `CHK(event_irq, 1'b0)
    wr(ADDR_SVC_CLEAR, 32'h0000000C);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_masked();
    t_order();
    t_rank();
    t_robin();
    t_global();
    t_event();
    results();
  end
endmodule
bind ivp_irq_ctrl ivp_checker u_ivp_checker (.core_clk(core_clk), .rst_n(rst_n),
  .av_req(av_req), .av_waitrequest(av_waitrequest), .av_readdata(av_readdata),
  .source_req(source_req), .normal_irq(normal_irq), .fast_irq(fast_irq),
  .event_irq(event_irq));
